// >>> sim/serial_led_pwm_dimmer_test.sv
// Testbench of the serial LED PWM dimmer
`timescale 1ns/10ps
module serial_led_pwm_dimmer_test;
    typedef struct {logic [3:0] res; logic st; logic ae; logic [11:0] smax;}
        sldpwm_row_s;
    // Rising resolutions, so a row never starts above its step range
    sldpwm_row_s rows [5] = '{'{4'h8, 1'b0, 1'b1, 12'h0ff},
        '{4'h9, 1'b1, 1'b0, 12'h1ff}, '{4'ha, 1'b0, 1'b0, 12'h3ff},
        '{4'hb, 1'b1, 1'b1, 12'h7ff}, '{4'hc, 1'b1, 1'b0, 12'hfff}};
    logic clk, rst, link_clk, link_rst, static_mode, latch_at_end, enable;
    logic map_we, driver_serial_in, driver_clk, latch_pulse, wrapped;
    logic driver_serial_out, tx_buffer_empty, frame_done;
    logic [3:0] resolution;
    logic [15:0] tick_period;
    logic [4:0] map_addr;
    logic [11:0] map_data, step_index, top, prev;
    logic [31:0] shreg, outq, exp_frame, last_sh;
    int fails = 0;
    int comparisons = 0;
    sldpwm_top u_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
        .link_rst(link_rst), .resolution(resolution),
        .tick_period(tick_period), .static_mode(static_mode),
        .latch_at_end(latch_at_end), .enable(enable), .map_we(map_we),
        .map_addr(map_addr), .map_data(map_data),
        .driver_serial_in(driver_serial_in), .driver_clk(driver_clk),
        .latch_pulse(latch_pulse), .driver_serial_out(driver_serial_out),
        .tx_buffer_empty(tx_buffer_empty), .frame_done(frame_done),
        .step_index(step_index));
    sldpwm_chain_model u_chain (.driver_clk(driver_clk),
        .driver_serial_in(driver_serial_in), .latch_pulse(latch_pulse),
        .driver_serial_out(driver_serial_out), .shift_q(shreg), .out_q(outq));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic results();
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    task automatic next_frame();
        int n;
        n = 0;
        @(negedge clk);
        while (frame_done !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check("frame_done", 32'h1, 32'(frame_done));
    endtask : next_frame
    // Even brightness: frames of steps 2k and 2k+1 agree, so any odd step
    // check holds whichever of the two steps the frame was built for
    task automatic frame_check(input logic ae);
        for (int i = 0; i < 32; i++) begin
            exp_frame[31 - i] = 12'(2 * i) > step_index;
        end
        if (step_index[0]) check("frame", exp_frame, shreg);
        if (ae) check("latched", shreg, outq);
        // Latch at tick must commit the old frame before any new bit
        if (!ae) check("held", last_sh, outq);
        last_sh = shreg;
    endtask : frame_check
    initial begin
        {rst, link_rst, static_mode, latch_at_end, enable, map_we} = 6'h30;
        resolution = 4'h8;
        tick_period = 16'h0050;
        map_addr = 5'h00;
        map_data = 12'h000;
        repeat (5) @(negedge clk);
        {rst, link_rst, map_we} = 3'b001;
        for (int i = 0; i < 32; i++) begin
            map_addr = 5'(i);
            map_data = 12'(2 * i);
            @(negedge clk);
        end
        map_we = 1'b0;
        enable = 1'b1;
        foreach (rows[r]) begin
            resolution = rows[r].res;
            static_mode = rows[r].st;
            latch_at_end = rows[r].ae;
            repeat (40) begin
                next_frame();
                frame_check(rows[r].ae);
                check("step", 32'h1, 32'(step_index <= rows[r].smax));
            end
        end
        // Reset in mid-run, then a full step wrap at 8 bits
        {rst, link_rst} = 2'b11;
        repeat (2) @(negedge clk);
        check("reset", 32'h0, {latch_pulse, driver_clk, step_index});
        {resolution, latch_at_end, rst, link_rst} = 7'h44;
        {top, prev, wrapped} = 25'h0;
        repeat (300) begin
            next_frame();
            if (step_index > top) top = step_index;
            if (step_index < prev) wrapped = 1'b1;
            prev = step_index;
        end
        check("step top", 32'h0ff, 32'(top));
        check("step wrap", 32'h1, 32'(wrapped));
        results();
    end
    initial begin
        #(25.0 * 70000);
        fails++;
        results();
    end
endmodule : serial_led_pwm_dimmer_test

// >>> sim/sldpwm_chain_model.sv
// Model of a chain of shift-register LED drivers
`timescale 1ns/10ps
module sldpwm_chain_model (
    // Serial link
    input wire logic driver_clk,
    input wire logic driver_serial_in,
    input wire logic latch_pulse,
    // Chain return and observation
    output logic driver_serial_out,
    output logic [31:0] shift_q,
    output logic [31:0] out_q
);
    initial shift_q = 32'h0;
    initial out_q = 32'h0;
    always @(posedge driver_clk) shift_q <= {shift_q[30:0], driver_serial_in};
    always @(posedge latch_pulse) out_q <= shift_q;
    assign driver_serial_out = shift_q[31];
endmodule : sldpwm_chain_model

// >>> sim/sldpwm_chk.sv
// Checker of the serial LED PWM dimmer ports
`timescale 1ns/10ps
module sldpwm_chk (
    // Clocks and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    // Watched signals
    input wire logic latch_at_end,
    input wire logic driver_clk,
    input wire logic latch_pulse,
    input wire logic tx_buffer_empty,
    input wire logic frame_done,
    input wire logic [11:0] step_index
);
    // Rising serial edges mod 32; quiet at latch, so safe to read
    logic dclk_reg;
    logic [4:0] rise_reg;
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            dclk_reg <= 1'b0;
            rise_reg <= 5'h00;
        end else begin
            dclk_reg <= driver_clk;
            rise_reg <= rise_reg + 5'(driver_clk && !dclk_reg);
        end
    end
    AST_LATCH_SINGLE: assert property (
        @(posedge clk) disable iff (rst) latch_pulse |=> !latch_pulse)
        else $error("latch pulse longer than one cycle");
    AST_LATCH_IDLE: assert property (
        @(posedge clk) disable iff (rst) latch_pulse |-> !driver_clk)
        else $error("latch pulse while serial clock high");
    AST_LATCH_COUNT: assert property (
        @(posedge clk) disable iff (rst) latch_pulse |-> rise_reg == 5'h00)
        else $error("latch pulse off a frame boundary");
    // Mode is taken at the edge that raises frame done
    AST_LATCH_AT_END: assert property (
        @(posedge clk) disable iff (rst)
        frame_done |-> latch_pulse == $past(latch_at_end))
        else $error("latch pulse at frame end not as selected");
    AST_DONE_SINGLE: assert property (
        @(posedge clk) disable iff (rst) frame_done |=> !frame_done)
        else $error("frame done longer than one cycle");
    AST_STEP_SEQ: assert property (
        @(posedge clk) disable iff (rst) $changed(step_index) |->
        step_index == $past(step_index) + 12'h001 || step_index == 12'h000)
        else $error("step index skipped");
    AST_TX_BUSY: assert property (@(posedge link_clk)
        disable iff (link_rst) driver_clk |-> !tx_buffer_empty)
        else $error("buffer empty while shifting");
    AST_SCLK_HALF: assert property (@(posedge link_clk)
        disable iff (link_rst) $rose(driver_clk) |=> $fell(driver_clk))
        else $error("serial clock high too long");
endmodule : sldpwm_chk

bind sldpwm_top sldpwm_chk u_chk (.clk(clk), .rst(rst),
    .link_clk(link_clk), .link_rst(link_rst), .latch_at_end(latch_at_end),
    .driver_clk(driver_clk), .latch_pulse(latch_pulse),
    .tx_buffer_empty(tx_buffer_empty), .frame_done(frame_done),
    .step_index(step_index));

// >>> verilog/sldpwm_pkg.sv
// Package of constants for the serial LED PWM dimmer
package sldpwm_pkg;
    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int LED_COUNT = 32;
    localparam int BYTES_PER_FRAME = LED_COUNT / 8;
    localparam int BRIGHT_W = 12;
    localparam int STEP_W = 12;
    localparam int LED_IDX_W = 5;
    localparam int BIT_IDX_W = 3;
    // ------------------------------------------------------------
    // Resolution
    // ------------------------------------------------------------
    localparam logic [3:0] RES_MIN = 4'h8;
    localparam logic [3:0] RES_MAX = 4'hc;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int SCLK_DIV = 2;
    localparam logic [15:0] TICK_RESET = 16'h0100;
    localparam logic [3:0] RES_RESET = 4'h8;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATCH = 3'b001,
        ST_LOAD = 3'b010,
        ST_LOW = 3'b011,
        ST_HIGH = 3'b100,
        ST_WAIT = 3'b101
    } sldpwm_state_e;
endpackage : sldpwm_pkg

// >>> verilog/sldpwm_top.sv
// Serial LED PWM dimmer: brightness map, step frames, serial output
`timescale 1ns/10ps
module sldpwm_top (
    // System
    input wire logic clk,
    input wire logic rst,
    // Link clock domain
    input wire logic link_clk,
    input wire logic link_rst,
    // Configuration
    input wire logic [3:0] resolution,
    input wire logic [15:0] tick_period,
    input wire logic static_mode,
    input wire logic latch_at_end,
    input wire logic enable,
    // Brightness map write
    input wire logic map_we,
    input wire logic [4:0] map_addr,
    input wire logic [11:0] map_data,
    // Driver link
    output logic driver_serial_in,
    output logic driver_clk,
    output logic latch_pulse,
    input wire logic driver_serial_out,
    // Status
    output logic tx_buffer_empty,
    output logic frame_done,
    output logic [11:0] step_index
);
    // ------------------------------------------------------------
    // Brightness map and step table
    // ------------------------------------------------------------
    // brightness map
    logic [11:0] brightness_map [0:31];
    logic [31:0] step_frame_buffer [0:4095];
    logic [11:0] step_reg, step_next;
    logic [11:0] fill_reg;
    logic fill_busy_reg;
    logic [31:0] dyn_frame;
    logic [31:0] fill_frame;
    logic [12:0] step_count;
    logic [11:0] step_last;

    wire [3:0] res_eff = (resolution < sldpwm_pkg::RES_MIN) ?
        sldpwm_pkg::RES_MIN : (resolution > sldpwm_pkg::RES_MAX) ?
        sldpwm_pkg::RES_MAX : resolution;
    assign step_count = 13'h0001 << res_eff;
    assign step_last = 12'(step_count - 13'h0001);

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_cmp
            // bit set when brightness exceeds step, LED 0 at MSB
            assign dyn_frame[31 - g] = brightness_map[g] > step_reg;
            assign fill_frame[31 - g] = brightness_map[g] > fill_reg;
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (map_we) begin
            brightness_map[map_addr] <= map_data;
        end
        if (fill_busy_reg) begin
            step_frame_buffer[fill_reg] <= fill_frame;
        end
    end

    // Table refill after any map write; dynamic frames cover the gap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_reg <= 12'h000;
            fill_busy_reg <= 1'b1;
        end else if (map_we) begin
            fill_reg <= 12'h000;
            fill_busy_reg <= 1'b1;
        end else if (fill_busy_reg) begin
            fill_reg <= fill_reg + 12'h001;
            fill_busy_reg <= fill_reg != 12'hfff;
        end
    end

    // ------------------------------------------------------------
    // Step timer
    // ------------------------------------------------------------
    logic [15:0] tick_cnt_reg;
    // programmable step timer sets the rate
    wire tick = enable && (tick_cnt_reg == 16'h0000);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= sldpwm_pkg::TICK_RESET;
        end else if (!enable || tick_cnt_reg == 16'h0000) begin
            tick_cnt_reg <= tick_period;
        end else begin
            tick_cnt_reg <= tick_cnt_reg - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer (system clock)
    // ------------------------------------------------------------
    sldpwm_pkg::sldpwm_state_e st_reg;
    logic [31:0] frame_reg;
    logic [1:0] byte_reg;
    logic pend_latch_reg;
    logic req_tog_reg;
    logic [7:0] word_reg;
    logic ack_s1_reg, ack_s2_reg;
    logic ack_tog_reg;
    logic latch_reg, done_reg;

    wire link_idle = (req_tog_reg == ack_s2_reg);
    // static mode fetches the prepared frame once the refill is done
    wire use_table = static_mode && !fill_busy_reg;
    wire [31:0] frame_src = use_table ? step_frame_buffer[step_reg]
        : dyn_frame;
    // pointer advances one frame and wraps
    assign step_next = (step_reg >= step_last) ? 12'h000
        : step_reg + 12'h001;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_tog_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= sldpwm_pkg::ST_IDLE;
            step_reg <= 12'h000;
            frame_reg <= 32'h0000_0000;
            byte_reg <= 2'h0;
            pend_latch_reg <= 1'b0;
            req_tog_reg <= 1'b0;
            word_reg <= 8'h00;
            latch_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            latch_reg <= 1'b0;
            done_reg <= 1'b0;
            unique case (st_reg)
                sldpwm_pkg::ST_IDLE: begin
                    if (tick) begin
                        st_reg <= sldpwm_pkg::ST_LATCH;
                    end
                end
                sldpwm_pkg::ST_LATCH: begin
                    if (link_idle) begin
                        latch_reg <= pend_latch_reg;
                        pend_latch_reg <= 1'b0;
                        frame_reg <= frame_src;
                        step_reg <= step_next;
                        byte_reg <= 2'h0;
                        st_reg <= sldpwm_pkg::ST_LOAD;
                    end
                end
                sldpwm_pkg::ST_LOAD: begin
                    // load a byte only when buffer empty
                    if (link_idle) begin
                        word_reg <= frame_reg[31:24];
                        frame_reg <= {frame_reg[23:0], 8'h00};
                        req_tog_reg <= ~req_tog_reg;
                        st_reg <= sldpwm_pkg::ST_WAIT;
                    end
                end
                sldpwm_pkg::ST_WAIT: begin
                    if (link_idle) begin
                        byte_reg <= byte_reg + 2'h1;
                        if (byte_reg == 2'h3) begin
                            done_reg <= 1'b1;
                            // latch at end, else at next tick
                            // one latch per 32 serial clocks
                            latch_reg <= latch_at_end;
                            pend_latch_reg <= !latch_at_end;
                            st_reg <= sldpwm_pkg::ST_IDLE;
                        end else begin
                            st_reg <= sldpwm_pkg::ST_LOAD;
                        end
                    end
                end
                default: begin
                    st_reg <= sldpwm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign latch_pulse = latch_reg;
    assign frame_done = done_reg;
    assign step_index = step_reg;
    assign tx_buffer_empty = link_idle;

    // ------------------------------------------------------------
    // Serializer (link clock)
    // ------------------------------------------------------------
    // Word is stable while the toggle is unacknowledged, so it
    // crosses without its own synchroniser.
    logic req_s1_reg, req_s2_reg;
    logic [7:0] sh_reg;
    logic [2:0] bit_reg;
    logic busy_reg, sclk_reg, sdi_reg;

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            ack_tog_reg <= 1'b0;
            sh_reg <= 8'h00;
            bit_reg <= 3'h0;
            busy_reg <= 1'b0;
            sclk_reg <= 1'b0;
            sdi_reg <= 1'b0;
        end else begin
            req_s1_reg <= req_tog_reg;
            req_s2_reg <= req_s1_reg;
            if (!busy_reg && req_s2_reg != ack_tog_reg) begin
                sh_reg <= word_reg;
                sdi_reg <= word_reg[7];
                bit_reg <= 3'h0;
                busy_reg <= 1'b1;
            end else if (busy_reg && !sclk_reg) begin
                // driver samples on this rising edge
                sclk_reg <= 1'b1;
            end else if (busy_reg) begin
                // one bit per link clock pair, MSB first
                sclk_reg <= 1'b0;
                sh_reg <= {sh_reg[6:0], 1'b0};
                sdi_reg <= sh_reg[6];
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    busy_reg <= 1'b0;
                    ack_tog_reg <= ~ack_tog_reg;
                end
            end
        end
    end

    assign driver_serial_in = sdi_reg;
    assign driver_clk = sclk_reg;
    // driver copies on latch; readback unused here
    wire unused_sdo = driver_serial_out;
endmodule : sldpwm_top
